/* hdl/mdws_pkg.sv */
// constants and types for the waveform sequencer
package mdws_pkg;
	// register indices; the byte address is four times the index
	localparam logic [5:0] IX_CTRL  = 6'h00;
	localparam logic [5:0] IX_PRE   = 6'h02;
	localparam logic [5:0] IX_CNT   = 6'h04;
	localparam logic [5:0] IX_WDAT  = 6'h06;
	localparam logic [5:0] IX_WPTR  = 6'h08;
	localparam logic [5:0] IX_START = 6'h0e;
	localparam logic [5:0] IX_HOLD  = 6'h10;
	localparam logic [5:0] IX_VEC   = 6'h21;
	// control field positions
	localparam int CTRL_BANK_LSB = 0;
	localparam int CTRL_AUTOINC  = 4;
	localparam int CTRL_TRIG_LSB = 5;
	localparam int CTRL_SYNC_OUT = 7;
	localparam int CTRL_MODE_LSB = 8;
	// values after reset
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [7:0]  PRE_RST  = 8'h00;
	localparam logic [15:0] CNT_RST  = 16'h0000;
	localparam logic [15:0] HOLD_RST = 16'h0000;
	localparam logic [7:0]  VEC_RST  = 8'h00;
	// trigger source selection
	localparam logic [1:0] TRIG_ALL      = 2'b00;
	localparam logic [1:0] TRIG_EXT_ONLY = 2'b01;
	// timing
	localparam int CLK_KHZ      = 50000;
	localparam int TICK_KHZ     = 8000;
	localparam int SYNC_PULSE_NS = 500;
	localparam int SYNC_PULSE_CYC = (SYNC_PULSE_NS * CLK_KHZ + 999999) / 1000000;

	typedef enum logic [2:0] {
		MODE_OFF         = 3'b000,
		MODE_SINGLE_HOLD = 3'b001,
		MODE_SINGLE_WAVE = 3'b010,
		MODE_ONCE        = 3'b011,
		MODE_ONCE_IRQ    = 3'b100,
		MODE_CONT        = 3'b101
	} mdws_mode_e;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FETCH = 2'b01,
		ST_LOAD  = 2'b10
	} mdws_state_e;
endpackage

/* hdl/mdws_top.sv */
// eight-channel converter update sequencer with waveform memory
// Functional notes
// [R1] codes 011 and 100 on control bits 10:8 run one pass; 100 adds interrupt
// [R2] one-pass mode converts per pace event until all locations done, then stops
// [R3] code 101 cycles waveform memory endlessly once started
// [R4] continuous mode moves one word per channel at each timer or trigger event
// [R5] in memory modes software start or external trigger begins the update
// [R6] trigger field 01 starts conversions only on a low-going sync pulse
// [R7] in external-only mode each pulse updates all; timer has no effect
// [R8] in external-only mode the sync pin is an input
// [R9] a continuous-mode master drives sync pin to followers in external-only mode
// [R10] control 0100H selects single update from holding registers, all sources
// [R11] bit 0 written to start location triggers simultaneous update of all channels
// [R12] control 0200H selects single update from memory, bank 0, all sources
// [R13] low control bits select the bank that the host accesses
// [R14] pointer write sets location for the next data access
// [R15] data write stores the word at pointer in the selected bank
// [R16] with auto-increment the pointer advances after each data write
// [R17] interval equals prescaler times count base ticks
// [R18] channel words are two's complement and passed unchanged
// [R19] code 100 raises interrupt when one pass completes
// [R20] interrupt request is active low, released on acknowledge
// [R21] host-writable eight-bit vector at index 21H
// [R22] one pass covers locations zero to 2047 per channel
// [R23] acknowledge select drives the vector and removes the request
// [R24] external-only mode ignores the software start bit
// [R25] trigger field 00 accepts software, external and timer starts
`timescale 1ns/10ps
module mdws_top
	import mdws_pkg::*;
#(
	parameter int NCH   = 8,
	parameter int DW    = 16,
	parameter int DEPTH = 2048,
	parameter int AW    = 11,
	parameter int CHW   = 3
) (
	input  wire logic              CLK_IN,
	input  wire logic              RESETN_IN,
	input  wire logic              WB_CYC_IN,
	input  wire logic              WB_STB_IN,
	input  wire logic              WB_WE_IN,
	input  wire logic [7:0]        WB_ADR_IN,
	input  wire logic [3:0]        WB_SEL_IN,
	input  wire logic [31:0]       WB_DAT_IN,
	output logic      [31:0]       WB_DAT_OUT,
	output logic                   WB_ACK_OUT,
	input  wire logic              EXT_SYNC_PULSE_N_IN,
	output logic                   EXT_SYNC_PULSE_N_OUT,
	output logic                   EXT_SYNC_PULSE_N_OE_N_OUT,
	output logic      [NCH*DW-1:0] DAC_DATA_OUT,
	output logic                   DAC_LOAD_OUT,
	output logic                   INT_REQ_N_OUT,
	input  wire logic              INT_SEL_N_IN,
	output logic      [7:0]        INT_VEC_OUT,
	output logic                   INT_ACK_OUT
);
	logic [15:0]     ctrl_q;
	logic [7:0]      pre_q;
	logic [15:0]     cnt_q;
	logic [AW-1:0]   wptr_q;
	logic [DW-1:0]   hold_q [NCH];
	logic [7:0]      vec_q;
	logic            ack_q;
	logic [31:0]     dat_q;
	logic [DW-1:0]   wave_mem [0:NCH*DEPTH-1];
	logic [DW-1:0]   shadow_q [NCH];
	logic [NCH*DW-1:0] dac_q;
	logic            load_q;
	mdws_state_e     state_q;
	logic [CHW-1:0]  fch_q;
	logic [AW-1:0]   play_q;
	logic            run_q;
	logic            ext_prev_q;
	logic [15:0]     phase_q;
	logic [7:0]      pre_cnt_q;
	logic [15:0]     int_cnt_q;
	logic [7:0]      pulse_q;
	logic            sync_n_q;
	logic            irq_q;
	logic            iack_q;
	logic [7:0]      ivec_q;

	localparam logic [15:0] PH_INC = 16'(TICK_KHZ);
	localparam logic [15:0] PH_MOD = 16'(CLK_KHZ);
	localparam logic [7:0]  PULSE_LEN = 8'(SYNC_PULSE_CYC);
	localparam logic [AW-1:0] LAST_LOC = AW'(DEPTH - 1);
	localparam logic [CHW-1:0] LAST_CH = CHW'(NCH - 1);

	function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
			input logic [1:0] s);
		merge = {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
	endfunction

	function automatic logic [CHW+AW-1:0] mem_ix(input logic [CHW-1:0] c,
			input logic [AW-1:0] a);
		mem_ix = {c, a};
	endfunction

	wire logic        req     = WB_CYC_IN & WB_STB_IN & ~ack_q;
	wire logic [5:0]  ix      = WB_ADR_IN[7:2];
	wire logic        wr      = req & WB_WE_IN;
	wire logic [15:0] wdat    = WB_DAT_IN[15:0];
	wire logic [1:0]  sel     = WB_SEL_IN[1:0];
	wire logic        hold_hit = (ix[5:4] == 2'b01) & ~ix[0];
	wire logic        ctrl_wr = wr & (ix == IX_CTRL);
	wire logic [2:0]  mode    = ctrl_q[CTRL_MODE_LSB +: 3];
	wire logic [CHW-1:0] bank = ctrl_q[CTRL_BANK_LSB +: CHW];
	wire logic        ext_only = ctrl_q[CTRL_TRIG_LSB +: 2] == TRIG_EXT_ONLY;
	wire logic        is_once = (mode == MODE_ONCE) | (mode == MODE_ONCE_IRQ);
	wire logic        cycling = is_once | (mode == MODE_CONT);
	wire logic        single  = (mode == MODE_SINGLE_HOLD) | (mode == MODE_SINGLE_WAVE);
	// the master watches its own pulse on the pin; ignore it so it cannot retrigger
	wire logic        drive_sync = ctrl_q[CTRL_SYNC_OUT] & (mode == MODE_CONT) & ~ext_only;
	wire logic        ext_fall = ext_prev_q & ~EXT_SYNC_PULSE_N_IN & ~drive_sync;
	// [R24] start bit blocked
	wire logic        sw_start = wr & (ix == IX_START) & sel[0] & wdat[0] & ~ext_only;
	// [R25] all sources unless external-only
	wire logic        start_ev = sw_start | ext_fall;
	wire logic [16:0] ph_sum  = {1'b0, phase_q} + {1'b0, PH_INC};
	wire logic        tick    = ph_sum >= {1'b0, PH_MOD};
	wire logic        tmr_on  = run_q & cycling & ~ext_only;
	logic             tmr_exp;
	logic             conv_req;
	logic             pass_end;
	// a function result cannot be part-selected, so the merged pointer word gets its own name
	logic [15:0]      wptr_wr;

	// [R7] timer gated off
	assign tmr_exp  = tmr_on & tick & (pre_cnt_q <= 8'h01) & (int_cnt_q <= 16'h0001);
	// [R5] start or pace
	assign conv_req = (state_q == ST_IDLE) &
		(single ? start_ev : (cycling & (run_q ? (ext_fall | tmr_exp) : start_ev)));
	// [R22] last location
	assign pass_end = (state_q == ST_LOAD) & run_q & cycling & (play_q == LAST_LOC);
	assign wptr_wr  = merge(16'(wptr_q), wdat, sel);

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req) begin
				dat_q <= 32'h0000_0000;
				case (ix)
					IX_CTRL: dat_q[15:0] <= ctrl_q;
					IX_PRE:  dat_q[7:0]  <= pre_q;
					IX_CNT:  dat_q[15:0] <= cnt_q;
					IX_WDAT: dat_q[DW-1:0] <= wave_mem[mem_ix(bank, wptr_q)];
					IX_WPTR: dat_q[AW-1:0] <= wptr_q;
					IX_VEC:  dat_q[7:0]  <= vec_q;
					default: dat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ctrl_q <= CTRL_RST;
			pre_q  <= PRE_RST;
			cnt_q  <= CNT_RST;
			vec_q  <= VEC_RST;
			for (int i = 0; i < NCH; i++) begin
				hold_q[i] <= HOLD_RST;
			end
		end else if (wr) begin
			// [R10] [R12] [R13] control write
			if (ix == IX_CTRL) ctrl_q <= merge(ctrl_q, wdat, sel);
			// [R17] interval values
			if (ix == IX_PRE && sel[0]) pre_q <= wdat[7:0];
			if (ix == IX_CNT) cnt_q <= merge(cnt_q, wdat, sel);
			// [R21] vector store
			if (ix == IX_VEC && sel[0]) vec_q <= wdat[7:0];
			if (hold_hit) hold_q[ix[3:1]] <= merge(hold_q[ix[3:1]], wdat, sel);
		end
	end

	// [R14] [R16] pointer load and advance
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			wptr_q <= '0;
		end else if (wr && ix == IX_WPTR) begin
			wptr_q <= wptr_wr[AW-1:0];
		end else if (wr && ix == IX_WDAT && ctrl_q[CTRL_AUTOINC]) begin
			wptr_q <= wptr_q + 1'b1;
		end
	end

	// [R15] memory write; memory contents are not cleared by reset
	always_ff @(posedge CLK_IN) begin
		if (wr && ix == IX_WDAT) begin
			wave_mem[mem_ix(bank, wptr_q)] <= merge(wave_mem[mem_ix(bank, wptr_q)], wdat, sel);
		end
	end

	// [R17] fractional base tick then prescaler and count
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			phase_q   <= 16'h0000;
			pre_cnt_q <= 8'h00;
			int_cnt_q <= 16'h0000;
		end else begin
			phase_q <= tick ? 16'(ph_sum - {1'b0, PH_MOD}) : ph_sum[15:0];
			if (!tmr_on) begin
				pre_cnt_q <= pre_q;
				int_cnt_q <= cnt_q;
			end else if (tick) begin
				if (pre_cnt_q <= 8'h01) begin
					pre_cnt_q <= pre_q;
					int_cnt_q <= (int_cnt_q <= 16'h0001) ? cnt_q : int_cnt_q - 1'b1;
				end else begin
					pre_cnt_q <= pre_cnt_q - 1'b1;
				end
			end
		end
	end

	// [R6] [R8] pin sampled as input edge
	// resets to the pin's idle level, so release of reset makes no false edge
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) ext_prev_q <= 1'b1;
		else ext_prev_q <= EXT_SYNC_PULSE_N_IN;
	end

	// [R1] [R2] [R3] run control and playback location
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			run_q  <= 1'b0;
			play_q <= '0;
		end else if (ctrl_wr) begin
			run_q  <= 1'b0;
			play_q <= '0;
		end else if (state_q == ST_LOAD && run_q && cycling) begin
			play_q <= play_q + 1'b1;
			if (pass_end && is_once) run_q <= 1'b0;
		end else if (conv_req && cycling && !run_q) begin
			run_q <= 1'b1;
		end
	end

	// [R4] [R11] fetch all channels from memory, or copy the holding registers, then load together
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			state_q <= ST_IDLE;
			fch_q   <= '0;
			load_q  <= 1'b0;
			dac_q   <= '0;
			for (int i = 0; i < NCH; i++) begin
				shadow_q[i] <= '0;
			end
		end else begin
			load_q <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					fch_q <= '0;
					if (conv_req && mode == MODE_SINGLE_HOLD) begin
						shadow_q <= hold_q;
						state_q  <= ST_LOAD;
					end else if (conv_req) begin
						state_q <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					shadow_q[fch_q] <= wave_mem[mem_ix(fch_q, play_q)];
					fch_q <= fch_q + 1'b1;
					if (fch_q == LAST_CH) state_q <= ST_LOAD;
				end
				ST_LOAD: begin
					// [R18] words pass unaltered
					for (int i = 0; i < NCH; i++) begin
						dac_q[i*DW +: DW] <= shadow_q[i];
					end
					load_q  <= 1'b1;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// [R9] master pulse at each load
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			pulse_q  <= 8'h00;
			sync_n_q <= 1'b1;
		end else begin
			if (load_q && drive_sync) pulse_q <= PULSE_LEN;
			else if (pulse_q != 8'h00) pulse_q <= pulse_q - 1'b1;
			sync_n_q <= (pulse_q == 8'h00);
		end
	end

	// [R19] [R20] [R23] request set wins over acknowledge
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			irq_q  <= 1'b0;
			iack_q <= 1'b0;
			ivec_q <= 8'h00;
		end else begin
			iack_q <= ~INT_SEL_N_IN & ~iack_q;
			if (~INT_SEL_N_IN & ~iack_q) ivec_q <= vec_q;
			if (pass_end && mode == MODE_ONCE_IRQ) irq_q <= 1'b1;
			else if (~INT_SEL_N_IN & ~iack_q) irq_q <= 1'b0;
		end
	end

	assign WB_ACK_OUT = ack_q;
	assign WB_DAT_OUT = dat_q;
	assign DAC_DATA_OUT = dac_q;
	assign DAC_LOAD_OUT = load_q;
	assign EXT_SYNC_PULSE_N_OUT = sync_n_q;
	assign EXT_SYNC_PULSE_N_OE_N_OUT = ~drive_sync;
	assign INT_REQ_N_OUT = ~irq_q;
	assign INT_VEC_OUT = ivec_q;
	assign INT_ACK_OUT = iack_q;

	a_bus_ack_pulse: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		req |=> WB_ACK_OUT ##1 !WB_ACK_OUT) else $error("ack not a one-cycle answer");
	a_extonly_no_start: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R24]
		(ext_only && state_q == ST_IDLE && !ext_fall) |=> state_q == ST_IDLE)
		else $error("conversion began without sync pulse");
	a_wave_latency: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R5]
		(conv_req && mode != MODE_SINGLE_HOLD) |=> !DAC_LOAD_OUT[*8] ##1 !DAC_LOAD_OUT
		##1 DAC_LOAD_OUT) else $error("memory update latency wrong");
	a_hold_latency: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R11]
		(conv_req && mode == MODE_SINGLE_HOLD) |-> ##2 DAC_LOAD_OUT)
		else $error("holding update latency wrong");
	a_once_stops: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R2]
		(pass_end && is_once && !ctrl_wr) |=> !run_q && play_q == '0)
		else $error("one pass did not stop");
	a_cont_wraps: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R3]
		(pass_end && mode == MODE_CONT && !ctrl_wr) |=> run_q && play_q == '0)
		else $error("continuous run did not wrap");
	a_irq_on_pass: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R19]
		(pass_end && mode == MODE_ONCE_IRQ) |=> !INT_REQ_N_OUT)
		else $error("no interrupt after pass");
	a_irq_release: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R23]
		(!INT_SEL_N_IN && !iack_q && !pass_end) |=> INT_REQ_N_OUT && INT_ACK_OUT
		&& INT_VEC_OUT == $past(vec_q)) else $error("acknowledge did not release");
	a_ptr_advance: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R16]
		(wr && ix == IX_WDAT && ctrl_q[CTRL_AUTOINC]) |=> wptr_q == $past(wptr_q) + 1'b1)
		else $error("pointer did not advance");
	a_timer_silent: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R7]
		ext_only |-> !tmr_exp) else $error("timer paced in external-only mode");
	a_sync_follows: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R9]
		(DAC_LOAD_OUT && drive_sync) |-> ##2 !EXT_SYNC_PULSE_N_OUT)
		else $error("master sync pulse missing after update");
	a_ext_starts: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R6]
		(ext_only && ext_fall && state_q == ST_IDLE && (single || cycling))
		|=> state_q != ST_IDLE) else $error("sync pulse did not start an update");
	a_any_source: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R25]
		(!ext_only && sw_start && state_q == ST_IDLE && single) |=> state_q != ST_IDLE)
		else $error("software start refused with all sources enabled");
	a_pin_input: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R8]
		ext_only |-> EXT_SYNC_PULSE_N_OE_N_OUT)
		else $error("sync pin driven in external-only mode");
	a_once_quiet: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // [R19]
		(pass_end && mode == MODE_ONCE && !irq_q) |=> INT_REQ_N_OUT)
		else $error("interrupt raised without interrupt mode");

	// main flows: holding update, pass end, acknowledge, master drive, sync-paced start

	c_hold_update: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		DAC_LOAD_OUT && mode == MODE_SINGLE_HOLD);
	c_pass_done: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		pass_end && is_once);
	c_irq_ack: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		!INT_REQ_N_OUT ##1 INT_ACK_OUT);
	c_sync_drive: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		!EXT_SYNC_PULSE_N_OUT && !EXT_SYNC_PULSE_N_OE_N_OUT);
	c_ext_update: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		ext_only && ext_fall && state_q == ST_IDLE);
endmodule

/* verif/mdws_sync_peer.sv */
// far-side peer on the shared sync pin, which has a pull-up
`timescale 1ns/10ps
module mdws_sync_peer (
	input  wire logic clk_in,
	input  wire logic fire_in,
	input  wire logic dut_val_in,
	input  wire logic dut_oe_n_in,
	output logic      pin_out
);
	logic [2:0] cnt_q = 3'h0;
	assign pin_out = (!dut_oe_n_in) ? dut_val_in : (cnt_q == 3'h0);
	always_ff @(posedge clk_in) begin
		if (fire_in)
			cnt_q <= 3'h4;
		else if (cnt_q != 3'h0)
			cnt_q <= cnt_q - 3'h1;
	end
endmodule

/* verif/mdws_top_tb.sv */
// self-checking bench for the waveform sequencer
`timescale 1ns/10ps
module mdws_top_tb;
	import mdws_pkg::*;
	logic         clk, rst_n, cyc, stb, we, fire, isel_n;
	logic         ack, sync_o, oe_n, load, ireq_n, iack, pin;
	logic [7:0]   adr, vec;
	logic [31:0]  wdat, rdat;
	logic [127:0] dac;
	logic [15:0]  q;
	logic [3:0]   sel, bsel;
	int           fail_count, n_compared, n, k;

	mdws_top dut (.CLK_IN(clk), .RESETN_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
		.WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
		.WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .EXT_SYNC_PULSE_N_IN(pin),
		.EXT_SYNC_PULSE_N_OUT(sync_o), .EXT_SYNC_PULSE_N_OE_N_OUT(oe_n),
		.DAC_DATA_OUT(dac), .DAC_LOAD_OUT(load), .INT_REQ_N_OUT(ireq_n),
		.INT_SEL_N_IN(isel_n), .INT_VEC_OUT(vec), .INT_ACK_OUT(iack));
	mdws_sync_peer peer (.clk_in(clk), .fire_in(fire), .dut_val_in(sync_o),
		.dut_oe_n_in(oe_n), .pin_out(pin));

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
			fail_count++;
		end
	endtask

	// one classic cycle; request held until ack is sampled high at a rising edge
	task automatic wb(input logic [5:0] ix, input logic w, input logic [15:0] d);
		int t;
		t = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= bsel;
		adr <= {ix, 2'b00};
		wdat <= {16'h0000, d};
		@(posedge clk);
		while (ack !== 1'b1) begin
			t++;
			if (t > 20) begin
				chk(16'h0, 16'h1);
				test_done;
			end
			@(posedge clk);
		end
		q = rdat[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wld(input int lim);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (load !== 1'b1 && n < lim);
		if (load !== 1'b1) begin
			chk(16'h0, 16'h1);
			test_done;
		end
	endtask

	task automatic cnt_ld(input int cycles);
		k = 0;
		repeat (cycles) begin
			@(negedge clk);
			if (load === 1'b1)
				k++;
		end
	endtask

	task automatic s_reset;
		wb(IX_CTRL, 1'b0, 16'h0);
		chk(q, CTRL_RST);
		wb(6'h3f, 1'b0, 16'h0);
		chk(q, 16'h0000);
		wb(IX_START, 1'b0, 16'h0);
		chk(q, 16'h0000);
		wb(IX_VEC, 1'b0, 16'h0);
		chk(q, {8'h00, VEC_RST});
		wb(IX_VEC, 1'b1, 16'h005a);
		// upper lane only: the eight-bit vector must keep its value
		bsel = 4'h2;
		wb(IX_VEC, 1'b1, 16'h00a5);
		bsel = 4'h3;
		wb(IX_VEC, 1'b0, 16'h0);
		chk(q, 16'h005a);
	endtask

	task automatic s_hold;
		wb(IX_CTRL, 1'b1, 16'h0100);
		wb(IX_HOLD, 1'b1, 16'h7fff);
		wb(IX_HOLD + 6'h02, 1'b1, 16'h8000);
		wb(IX_START, 1'b1, 16'h0001);
		wld(20);
		chk({15'h0, load}, 16'h1);
		chk(dac[15:0], 16'h7fff);
		chk(dac[31:16], 16'h8000);
	endtask

	task automatic s_wave;
		wb(IX_CTRL, 1'b1, 16'h0211);
		wb(IX_WPTR, 1'b1, 16'h0000);
		wb(IX_WDAT, 1'b1, 16'h1234);
		wb(IX_WDAT, 1'b1, 16'h5678);
		wb(IX_WPTR, 1'b0, 16'h0);
		chk(q, 16'h0002);
		wb(IX_WPTR, 1'b1, 16'h0001);
		wb(IX_WDAT, 1'b0, 16'h0);
		chk(q, 16'h5678);
		wb(IX_CTRL, 1'b1, 16'h0200);
		wb(IX_WPTR, 1'b1, 16'h0000);
		wb(IX_WDAT, 1'b1, 16'h8000);
		wb(IX_WPTR, 1'b0, 16'h0);
		chk(q, 16'h0000);
		wb(IX_START, 1'b1, 16'h0001);
		wld(30);
		chk({15'h0, load}, 16'h1);
		chk(dac[15:0], 16'h8000);
		chk(dac[31:16], 16'h1234);
	endtask

	task automatic s_ext;
		wb(IX_CTRL, 1'b1, 16'h0220);
		wb(IX_START, 1'b1, 16'h0001);
		cnt_ld(40);
		chk(k[15:0], 16'h0);
		@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		wld(30);
		chk({15'h0, load}, 16'h1);
		chk(dac[15:0], 16'h8000);
		wb(IX_CTRL, 1'b1, 16'h05a0);
		chk({15'h0, oe_n}, 16'h1);
	endtask

	task automatic s_once;
		wb(IX_PRE, 1'b1, 16'h0001);
		wb(IX_CNT, 1'b1, 16'h0001);
		wb(IX_CTRL, 1'b1, 16'h0400);
		wb(IX_START, 1'b1, 16'h0001);
		k = 0;
		n = 0;
		while (ireq_n !== 1'b0) begin
			if (n >= 60000) begin
				chk(16'h0, 16'h1);
				test_done;
			end
			@(negedge clk);
			n++;
			if (load === 1'b1)
				k++;
		end
		chk(k[15:0], 16'd2048);
		chk({15'h0, ireq_n}, 16'h0);
		cnt_ld(100);
		chk(k[15:0], 16'h0);
		@(posedge clk);
		isel_n <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (iack !== 1'b1 && n < 10);
		chk({15'h0, iack}, 16'h1);
		if (iack !== 1'b1)
			test_done;
		chk({8'h00, vec}, 16'h005a);
		chk({15'h0, ireq_n}, 16'h1);
		@(posedge clk);
		isel_n <= 1'b1;
	endtask

	task automatic s_cont;
		wb(IX_PRE, 1'b1, 16'h0002);
		wb(IX_CNT, 1'b1, 16'h0005);
		wb(IX_CTRL, 1'b1, 16'h0580);
		chk({15'h0, oe_n}, 16'h0);
		wb(IX_START, 1'b1, 16'h0001);
		wld(40);
		// the drive register goes low two edges after the update is shown
		repeat (2) @(negedge clk);
		chk({15'h0, pin}, 16'h0);
		wld(100);
		chk({15'h0, load}, 16'h1);
		wld(100);
		chk({15'h0, (n >= 61 && n <= 64)}, 16'h1);
		// reset in mid-run: outputs fall back and the run does not resume
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk(dac[15:0], 16'h0000);
		chk({14'h0, oe_n, ireq_n}, 16'h0003);
		rst_n <= 1'b1;
		wb(IX_CTRL, 1'b0, 16'h0);
		chk(q, CTRL_RST);
		cnt_ld(100);
		chk(k[15:0], 16'h0);
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		rst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		sel = 4'h0;
		bsel = 4'h3;
		fire = 1'b0;
		isel_n = 1'b1;
		fail_count = 0;
		n_compared = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		s_reset;
		s_hold;
		s_wave;
		s_ext;
		s_once;
		s_cont;
		test_done;
	end
endmodule
